// ==== spsd_top.sv ====
// serial peripheral status, error, rate and data buffer block with apb access
// Function
// (R1) byte landing in receive buffer sets rx full; irq when its enable set
// (R2) any data register read clears rx full; reset clears it
// (R3) error irq enable gates overrun and mode fault requests; reset clears
// (R4) byte arriving while rx full sets overrun; held byte kept, new lost
// (R5) overrun clears after status read seeing it, then data read
// (R6) slave: select rising mid-transfer faults; master: select low faults
// (R7) mode fault clears after status read seeing it, then control write
// (R8) tx buffer handing byte to shifter sets tx empty; irq when enabled
// (R9) software writes data register only while tx empty is high
// (R10) idle end moves queued byte to shifter within two cycles
// (R11) active slave defers shifter load until its transfer completes
// (R12) tx empty reads one after reset
// (R13) mode fault sets only with fault enable; clearing enable keeps flag
// (R14) master with fault enable low ignores select, pin released
// (R15) slave always uses select; fault enable only gates the flag
// (R16) rate field picks divisor 2, 8, 32, 128 in master; resets 00
// (R17) master serial clock is base clock over twice the divisor
// (R18) data writes fill tx buffer, reads return separate rx buffer
// (R19) software avoids read-modify-write on the data register
// (R20) slave when master bit 0 and select low; select high floats output
// (R21) error irq is gated or of both faults, merged with rx and tx
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module spsd_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        ss_n_i,
  output logic             ss_gpio_en,
  output logic             irq
);
  // ==========================================================
  // declarations
  logic [7:0]  ctrl_q;
  logic        eie_q;
  logic        mfe_q;
  logic [1:0]  rate_q;
  logic        rxf_q;
  logic        ovr_q;
  logic        mf_q;
  logic        txe_q;
  logic        ovr_seen_q;
  logic        mf_seen_q;
  logic [7:0]  tx_buf_q;
  logic [7:0]  rx_buf_q;
  logic [7:0]  sh_q;
  logic        out_q;
  logic        sck_q;
  logic [3:0]  edge_q;
  logic [31:0] prdata_q;
  logic [2:0]  sck_s_q;
  logic [1:0]  mosi_s_q;
  logic [1:0]  miso_s_q;
  logic [2:0]  ss_s_q;
  spsd_pkg::spsd_state_t state_q;
  logic        access;
  logic        rd_s;
  logic        rd_d;
  logic        wr_c;
  logic        wr_s;
  logic        wr_d;
  logic        mapped;
  logic [7:0]  stat_rd;
  logic        master;
  logic        ena;
  logic        cpha;
  logic        slave_act;
  logic        mst_run;
  logic        busy;
  logic        ss_low;
  logic        ss_rise;
  logic        ss_fall;
  logic        sck_edge;
  logic        tick;
  logic        edge_ev;
  logic        start0;
  logic        load;
  logic        sample;
  logic        done;
  logic        din;
  logic [7:0]  rx_byte;
  logic        full_now;
  logic        ovr_clr;
  logic        mf_set;
  logic        mf_clr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ==========================================================
  // apb slave: zero wait states, read data captured in setup
  assign access  = psel & penable;
  assign rd_s    = access & ~pwrite & hit(paddr, spsd_pkg::ADDR_STAT);
  assign rd_d    = access & ~pwrite & hit(paddr, spsd_pkg::ADDR_DATA);
  assign wr_c    = access & pwrite & hit(paddr, spsd_pkg::ADDR_CTRL);
  assign wr_s    = access & pwrite & hit(paddr, spsd_pkg::ADDR_STAT);
  assign wr_d    = access & pwrite & hit(paddr, spsd_pkg::ADDR_DATA);
  assign mapped  = hit(paddr, spsd_pkg::ADDR_CTRL) | hit(paddr, spsd_pkg::ADDR_STAT)
                 | hit(paddr, spsd_pkg::ADDR_DATA);
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_q;
  assign stat_rd = {rxf_q, eie_q, ovr_q, mf_q, txe_q, mfe_q, rate_q};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_q <= 32'h0000_0000;
      if (hit(paddr, spsd_pkg::ADDR_CTRL)) begin
        prdata_q[7:0] <= ctrl_q;
      end
      if (hit(paddr, spsd_pkg::ADDR_STAT)) begin
        prdata_q[7:0] <= stat_rd;
      end
      if (hit(paddr, spsd_pkg::ADDR_DATA)) begin
        prdata_q[7:0] <= rx_buf_q; // [R18]
      end
    end
  end

  // ==========================================================
  // control and configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= spsd_pkg::CTRL_RESET;
    end else if (wr_c) begin
      ctrl_q <= pwdata[7:0] & spsd_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      eie_q  <= 1'b0; // [R3]
      mfe_q  <= 1'b0;
      rate_q <= spsd_pkg::RATE_RESET; // [R16]
    end else if (wr_s) begin
      eie_q  <= pwdata[spsd_pkg::STAT_EIE];
      mfe_q  <= pwdata[spsd_pkg::STAT_MFE];
      rate_q <= pwdata[spsd_pkg::STAT_RHI:spsd_pkg::STAT_RLO];
    end
  end

  assign master     = ctrl_q[spsd_pkg::CTRL_MST];
  assign ena        = ctrl_q[spsd_pkg::CTRL_ENA];
  assign cpha       = ctrl_q[spsd_pkg::CTRL_CPHA];
  assign slave_act  = ena & ~master; // [R15]
  // a faulted master lets go of its outputs until software clears the fault
  assign mst_run    = ena & master & ~mf_q;
  assign ss_gpio_en = ena & master & ~mfe_q; // [R14]

  // ==========================================================
  // pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_s_q  <= 3'h0;
      mosi_s_q <= 2'h0;
      miso_s_q <= 2'h0;
      ss_s_q   <= 3'h7;
    end else begin
      sck_s_q  <= {sck_s_q[1:0], sck_i};
      mosi_s_q <= {mosi_s_q[0], mosi_i};
      miso_s_q <= {miso_s_q[0], miso_i};
      ss_s_q   <= {ss_s_q[1:0], ss_n_i};
    end
  end

  assign ss_low   = ~ss_s_q[1];
  assign ss_rise  = ss_s_q[1] & ~ss_s_q[2];
  assign ss_fall  = ~ss_s_q[1] & ss_s_q[2];
  assign sck_edge = sck_s_q[1] ^ sck_s_q[2];
  assign din      = master ? miso_s_q[1] : mosi_s_q[1];

  // ==========================================================
  // transfer sequencing
  assign busy = (state_q == spsd_pkg::ST_BUSY);

  spsd_baud u_baud (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (mst_run & busy),
    .rate    (rate_q),
    .tick    (tick)
  );

  // a slave ignores the serial clock while deselected
  assign edge_ev = mst_run ? tick
                 : (slave_act & ss_low & sck_edge & (busy | cpha)); // [R20]
  assign start0  = slave_act & ~cpha & ss_fall;
  // only an idle end accepts a byte into its shifter
  assign load    = ena & ~busy & ~txe_q & ~edge_ev & ~start0; // [R10] [R11]
  assign sample  = edge_ev & (edge_q[0] == cpha);
  assign done    = busy & edge_ev & (edge_q == spsd_pkg::LAST_EDGE);
  assign rx_byte = cpha ? {sh_q[6:0], din} : sh_q;

  always_ff @(posedge clk_sys) begin
    if (rst | ~ena) begin
      state_q <= spsd_pkg::ST_IDLE;
      edge_q  <= 4'h0;
    end else begin
      unique case (state_q)
        spsd_pkg::ST_IDLE: begin
          edge_q <= edge_ev ? 4'h1 : 4'h0;
          if ((mst_run & load) | start0 | (slave_act & edge_ev)) begin
            state_q <= spsd_pkg::ST_BUSY;
          end
        end
        spsd_pkg::ST_BUSY: begin
          if (done | (master & mf_q)) begin
            state_q <= spsd_pkg::ST_IDLE;
            edge_q  <= 4'h0;
          end else if (start0) begin
            edge_q <= 4'h0;
          end else if (edge_ev) begin
            edge_q <= edge_q + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sh_q <= 8'h00;
    end else if (load) begin
      sh_q <= tx_buf_q;
    end else if (sample) begin
      sh_q <= {sh_q[6:0], din};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_q <= 1'b0;
    end else if (load) begin
      out_q <= tx_buf_q[7];
    end else if (start0 | (edge_ev & ~sample)) begin
      out_q <= sh_q[7];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst | ~busy | ~mst_run) begin
      sck_q <= ctrl_q[spsd_pkg::CTRL_CPOL];
    end else if (tick) begin
      sck_q <= ~sck_q; // [R17]
    end
  end

  assign sck_o   = sck_q;
  assign sck_oe  = mst_run;
  assign mosi_o  = out_q;
  assign mosi_oe = mst_run;
  assign miso_o  = out_q;
  assign miso_oe = slave_act & ss_low; // [R20]

  // ==========================================================
  // data buffers
  always_ff @(posedge clk_sys) begin
    if (wr_d) begin
      tx_buf_q <= pwdata[7:0]; // [R18]
    end
  end

  // a read in the completing cycle frees the buffer in time
  assign full_now = rxf_q & ~rd_d;

  always_ff @(posedge clk_sys) begin
    if (done & ~full_now) begin
      rx_buf_q <= rx_byte; // [R4] [R18]
    end
  end

  // ==========================================================
  // status flags; a hardware set wins over a software clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxf_q <= 1'b0;
    end else if (done & ~full_now) begin
      rxf_q <= 1'b1; // [R1]
    end else if (rd_d) begin
      rxf_q <= 1'b0; // [R2]
    end
  end

  assign ovr_clr = rd_d & ovr_seen_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ovr_q <= 1'b0;
    end else if (done & full_now) begin
      ovr_q <= 1'b1; // [R4]
    end else if (ovr_clr) begin
      ovr_q <= 1'b0; // [R5]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst | ovr_clr) begin
      ovr_seen_q <= 1'b0;
    end else if (rd_s & prdata_q[spsd_pkg::STAT_OVR]) begin
      ovr_seen_q <= 1'b1; // [R5]
    end
  end

  assign mf_set = mfe_q & ((slave_act & busy & ss_rise)
                | (ena & master & ss_low)); // [R6] [R13] [R14] [R15]
  assign mf_clr = wr_c & mf_seen_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mf_q <= 1'b0;
    end else if (mf_set) begin
      mf_q <= 1'b1; // [R6]
    end else if (mf_clr) begin
      mf_q <= 1'b0; // [R7]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst | mf_clr) begin
      mf_seen_q <= 1'b0;
    end else if (rd_s & prdata_q[spsd_pkg::STAT_MF]) begin
      mf_seen_q <= 1'b1; // [R7]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txe_q <= 1'b1; // [R12]
    end else if (load) begin
      txe_q <= 1'b1; // [R8] [R10]
    end else if (wr_d) begin
      txe_q <= 1'b0;
    end
  end

  assign irq = (rxf_q & ctrl_q[spsd_pkg::CTRL_RIE])
             | (txe_q & ctrl_q[spsd_pkg::CTRL_TIE])
             | ((ovr_q | mf_q) & eie_q); // [R1] [R3] [R8] [R21]

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_queue;
    wr_d & txe_q & ~busy & ena;
  endsequence
  sequence s_tick2;
    ~tick ##1 tick;
  endsequence

  a_rx_set_on_done: assert property (done & ~full_now |=> rxf_q) // [R1]
    else $error("rx full not set after byte landed");
  a_rx_read_clear: assert property (rd_d & ~done |=> ~rxf_q) // [R2]
    else $error("data read left rx full set");
  a_err_gate_off: assert property ((ovr_q | mf_q) & ~eie_q
    & ~(rxf_q & ctrl_q[spsd_pkg::CTRL_RIE]) & ~(txe_q & ctrl_q[spsd_pkg::CTRL_TIE])
    |-> ~irq) // [R3]
    else $error("error irq not gated by enable");
  a_ovr_keep_old: assert property (done & full_now
    |=> ovr_q & (rx_buf_q == $past(rx_buf_q))) // [R4]
    else $error("overrun did not keep held byte");
  a_ovr_needs_seen: assert property (ovr_q & ~ovr_seen_q
    & ~(rd_s & prdata_q[spsd_pkg::STAT_OVR]) |=> ovr_q) // [R5]
    else $error("overrun cleared without status read");
  a_mf_master_low: assert property (ena & master & mfe_q & ss_low |=> mf_q) // [R6]
    else $error("master select low did not fault");
  a_mf_hold: assert property (mf_q & ~mf_clr |=> mf_q) // [R7]
    else $error("mode fault cleared without sequence");
  a_mf_disabled: assert property (~mfe_q & ~mf_q |=> ~mf_q) // [R13]
    else $error("mode fault set while disabled");
  a_idle_handoff: assert property (s_queue |-> ##[1:2] txe_q) // [R10]
    else $error("idle end did not take queued byte");
  a_slave_defer: assert property (slave_act & busy & ~done & ~txe_q
    |=> ~txe_q) // [R11]
    else $error("active slave loaded shifter early");
  a_reset_txe: assert property ($fell(rst) |-> txe_q) // [R12]
    else $error("tx empty low after reset");
  a_rate_fastest: assert property (tick & ~done & rate_q == 2'b00
    |=> s_tick2) // [R16]
    else $error("divide by two rate wrong");
  a_tx_write: assert property (wr_d |=> tx_buf_q == $past(pwdata[7:0])) // [R18]
    else $error("data write did not fill tx buffer");
  a_miso_float: assert property (ss_s_q[1] |-> ~miso_oe) // [R20]
    else $error("deselected slave drove its output");
endmodule

// ==== spsd_pkg.sv ====
// constants, register map and types for the serial status and data block
package spsd_pkg;
  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h0d;
  localparam logic [5:0] IDX_STAT = 6'h0e;
  localparam logic [5:0] IDX_DATA = 6'h0f;
  localparam logic [7:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] ADDR_STAT = {IDX_STAT, 2'b00};
  localparam logic [7:0] ADDR_DATA = {IDX_DATA, 2'b00};
  // ==========================================================
  // control register fields
  localparam int CTRL_RIE  = 7;
  localparam int CTRL_MST  = 5;
  localparam int CTRL_CPOL = 4;
  localparam int CTRL_CPHA = 3;
  localparam int CTRL_ENA  = 1;
  localparam int CTRL_TIE  = 0;
  localparam logic [7:0] CTRL_RESET = 8'h28;
  localparam logic [7:0] CTRL_WMASK = 8'hbb;
  // ==========================================================
  // status and control register fields
  localparam int STAT_RXF = 7;
  localparam int STAT_EIE = 6;
  localparam int STAT_OVR = 5;
  localparam int STAT_MF  = 4;
  localparam int STAT_TXE = 3;
  localparam int STAT_MFE = 2;
  localparam int STAT_RHI = 1;
  localparam int STAT_RLO = 0;
  localparam logic [1:0] RATE_RESET = 2'h0;
  // ==========================================================
  // transfer framing
  localparam logic [3:0] LAST_EDGE = 4'hf;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } spsd_state_t;
  // ==========================================================
  function automatic logic [7:0] rate_divisor(input logic [1:0] r);
    unique case (r)
      2'b00: rate_divisor = 8'h02;
      2'b01: rate_divisor = 8'h08;
      2'b10: rate_divisor = 8'h20;
      2'b11: rate_divisor = 8'h80;
    endcase
  endfunction
endpackage

// ==== spsd_baud.sv ====
// master serial clock half-period tick generator
`timescale 1ns/100ps
module spsd_baud (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] rate,
  output logic            tick
);
  logic [7:0] cnt_q;
  logic [7:0] div;

  assign div  = spsd_pkg::rate_divisor(rate);
  // one tick every divisor cycles: a toggle per tick gives clk/(2*div)
  assign tick = run & (cnt_q == div - 8'h01); // [R16] [R17]

  always_ff @(posedge clk_sys) begin
    if (rst | ~run | tick) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// ==== spsd_slave_model.sv ====
// behavioural remote serial slave on the far side of the master link
`timescale 1ns/100ps
module spsd_slave_model (
  input  wire logic       clk_sys,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  // ==========================================================
  // edge tracking; phase 1, idle low: drive on leading, sample on trailing
  logic       sck_prev = 1'b0;
  logic [3:0] edge_n   = 4'h0;
  logic       miso_q   = 1'b1;
  logic [7:0] rx_q     = 8'h00;

  assign miso    = miso_q;
  assign rx_byte = rx_q;

  always @(posedge clk_sys) begin
    sck_prev <= sck;
    // an unknown clock level is no edge, so reset noise cannot start a frame
    if ((sck ^ sck_prev) === 1'b1) begin
      edge_n <= edge_n + 4'h1;
      if (edge_n[0] == 1'b0) begin
        miso_q <= tx_byte[3'h7 - edge_n[3:1]];
      end else begin
        rx_q <= {rx_q[6:0], mosi};
        // line left undriven after the frame: show a changed level, not the last bit
        if (edge_n == 4'hf) begin
          miso_q <= ~miso_q;
        end
      end
    end
  end
endmodule

// ==== spi_status_and_data_regs_tb.sv ====
// self-checking bench for the serial status and data block
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, (a), (e)); end end
module spi_status_and_data_regs_tb;
  logic        clk_sys;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sck_o;
  logic        sck_oe;
  logic        mosi_o;
  logic        mosi_oe;
  logic        miso_i;
  logic        miso_o;
  logic        miso_oe;
  logic        ss_n_i;
  logic        ss_gpio_en;
  logic        irq;
  logic [7:0]  mdl_tx;
  logic [7:0]  mdl_rx;
  logic [31:0] rdata;
  logic        perr;
  logic        sck_in;
  logic        mosi_in;
  logic [7:0]  sgot;
  logic        sck_prev;
  int          err_total;
  int          cmp_count;
  int          cyc;
  int          last;
  int          half;
  int          edges;
  int          e0;
  int          n;
  int          div_tab [4] = '{2, 8, 32, 128};

  spsd_top i_dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_i(sck_in), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_in), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe),
    .ss_n_i(ss_n_i), .ss_gpio_en(ss_gpio_en), .irq(irq)
  );
  spsd_slave_model i_slave (
    .clk_sys(clk_sys), .sck(sck_o), .mosi(mosi_o), .miso(miso_i),
    .tx_byte(mdl_tx), .rx_byte(mdl_rx)
  );

  // ==========================================================
  // clock, serial clock half-period monitor, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if ((sck_o ^ sck_prev) === 1'b1) begin
      half = cyc - last;
      last = cyc;
      edges++;
    end
    sck_prev = sck_o;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    results();
  end

  // ==========================================================
  // apb master: hold the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin @(posedge clk_sys); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) err_total++;
    rdata = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // outputs launched by the access edge are looked at once settled
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d); apb(1'b1, a, {24'h0, d}); endtask
  task automatic rd(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask
  task automatic setss(input logic v);
    @(posedge clk_sys);
    ss_n_i <= v;
    repeat (6) @(posedge clk_sys);
  endtask

  // remote master on the slave link, phase 1, idle low: drives mosi on leading edges
  task automatic sxfer(input logic [7:0] b, input int n);
    for (int j = 0; j < n; j++) begin
      @(posedge clk_sys);
      sck_in  <= 1'b1;
      mosi_in <= b[7 - j];
      repeat (8) @(posedge clk_sys);
      sgot = {sgot[6:0], miso_o};
      sck_in  <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
  endtask

  // one byte out; software writes only while tx empty, then polls rx full
  task automatic xfer(input logic [7:0] b);
    int k;
    k = 0;
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[3], 1'b1)
    wr(spsd_pkg::ADDR_DATA, b);
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[3], 1'b1)
    do begin rd(spsd_pkg::ADDR_STAT); k++; end while (rdata[7] !== 1'b1 && k < 1000);
    `CHK(rdata[7], 1'b1)
  endtask

  task automatic results();
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    ss_n_i = 1'b1;
    sck_in = 1'b0;
    mosi_in = 1'b0;
    mdl_tx = 8'h00;
    {err_total, cmp_count} = '0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata, 32'h08)
    `CHK(irq, 1'b0)
    rd(8'h00);
    `CHK(perr, 1'b1)
    `CHK(rdata, 32'h0)
    // every rate code; at the fastest code the returned bit passes the synchroniser
    // after the master's sampling edge, so only the sent byte is checked there
    for (int r = 0; r < 4; r++) begin
      wr(spsd_pkg::ADDR_STAT, 8'(r));
      wr(spsd_pkg::ADDR_CTRL, 8'haa);
      `CHK(ss_gpio_en, 1'b1)
      mdl_tx = 8'h3c ^ 8'(r);
      xfer(8'hc3 ^ 8'(r));
      `CHK(half, div_tab[r])
      `CHK(irq, 1'b1)
      rd(spsd_pkg::ADDR_DATA);
      `CHK(mdl_rx, 8'hc3 ^ 8'(r))
      if (r != 0) begin
        `CHK(rdata, {24'h0, mdl_tx})
      end
      rd(spsd_pkg::ADDR_STAT);
      `CHK(rdata[7], 1'b0)
      `CHK(irq, 1'b0)
    end
    // overrun: second byte lands while the first is unread
    wr(spsd_pkg::ADDR_STAT, 8'h41);
    wr(spsd_pkg::ADDR_CTRL, 8'h2a);
    mdl_tx = 8'h11;
    xfer(8'h22);
    mdl_tx = 8'h99;
    e0 = edges;
    n = 0;
    wr(spsd_pkg::ADDR_DATA, 8'h44);
    while (edges < e0 + 16 && n < 2000) begin @(posedge clk_sys); n++; end
    repeat (20) @(posedge clk_sys);
    rd(spsd_pkg::ADDR_DATA);
    `CHK(rdata, 32'h11)
    `CHK(irq, 1'b1)
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[5], 1'b1)
    rd(spsd_pkg::ADDR_DATA);
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[5], 1'b0)
    `CHK(irq, 1'b0)
    // mode fault in master
    wr(spsd_pkg::ADDR_STAT, 8'h01);
    setss(1'b0);
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[4], 1'b0)
    setss(1'b1);
    wr(spsd_pkg::ADDR_STAT, 8'h05);
    `CHK(ss_gpio_en, 1'b0)
    setss(1'b0);
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[4], 1'b1)
    `CHK(sck_oe, 1'b0)
    `CHK(mosi_oe, 1'b0)
    setss(1'b1);
    wr(spsd_pkg::ADDR_STAT, 8'h01);
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[4], 1'b1)
    wr(spsd_pkg::ADDR_CTRL, 8'h2a);
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[4], 1'b0)
    // slave: select still governs the data output with fault enable low
    wr(spsd_pkg::ADDR_CTRL, 8'h0a);
    wr(spsd_pkg::ADDR_DATA, 8'h5a);
    `CHK(mosi_oe, 1'b0)
    setss(1'b0);
    `CHK(miso_oe, 1'b1)
    sxfer(8'ha5, 4);
    // a byte written mid-frame waits for the frame to end
    wr(spsd_pkg::ADDR_DATA, 8'h3c);
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[3], 1'b0)
    sxfer(8'h50, 4);
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[7], 1'b1)
    `CHK(rdata[3], 1'b1)
    `CHK(sgot, 8'h5a)
    rd(spsd_pkg::ADDR_DATA);
    `CHK(rdata, 32'ha5)
    setss(1'b1);
    `CHK(miso_oe, 1'b0)
    // select rising inside a frame faults once the enable is set
    wr(spsd_pkg::ADDR_STAT, 8'h04);
    setss(1'b0);
    @(posedge clk_sys);
    sck_in <= 1'b1;
    repeat (8) @(posedge clk_sys);
    setss(1'b1);
    rd(spsd_pkg::ADDR_STAT);
    `CHK(rdata[4], 1'b1)
    results();
  end
endmodule
